/* swk_top.sv */
`timescale 1ns/1ns
`default_nettype none
module swk_top #(
  parameter int TICK_CYCLES = swk_pkg::TICK_CYCLES
) (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_b_i,
  // Register port
  input  wire logic [swk_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [swk_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output logic      [swk_pkg::DATA_W-1:0] reg_rdata_o,
  // Calibrated analog channels
  input  wire logic [swk_pkg::AIN_W-1:0]  ain0_i,
  input  wire logic [swk_pkg::AIN_W-1:0]  ain1_i,
  input  wire logic [swk_pkg::AIN_W-1:0]  ain2_i,
  input  wire logic [swk_pkg::AIN_W-1:0]  ain3_i,
  input  wire logic [swk_pkg::NUM_AIN-1:0] ain_loss_i,
  // Drive command side
  input  wire logic                       permissives_ok_i,
  input  wire logic                       run_input_closed_i,
  input  wire logic                       running_i,
  input  wire logic                       fault_reset_i,
  input  wire logic                       start_cmd_i,
  input  wire logic                       local_ctrl_i,
  input  wire logic [swk_pkg::SEL_W-1:0]  local_port_i,
  input  wire logic                       local_start_i,
  input  wire logic                       din_start_i,
  input  wire logic                       jog_i,
  output logic                            drive_start_o,
  output logic                            drive_stop_o,
  output logic                            run_permit_o,
  output logic                            fault_reset_o,
  output logic                            awake_o,
  output logic                            crossed_o,
  output logic      [swk_pkg::NUM_AIN-1:0] ain_loss_o
);
  import swk_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [AIN_W-1:0] abs_val(input logic [AIN_W-1:0] v);
    abs_val = v[AIN_W-1] ? (~v + 1'b1) : v;
  endfunction : abs_val

  function automatic logic [DATA_W-1:0] zext16(input logic [AIN_W-1:0] v);
    zext16 = {{(DATA_W-AIN_W){1'b0}}, v};
  endfunction : zext16

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_reg;
  logic [AIN_W-1:0]  wake_level_reg;
  logic [AIN_W-1:0]  sleep_level_reg;
  logic [TMR_W-1:0]  wake_time_reg;
  logic [TMR_W-1:0]  sleep_time_reg;

  wire logic wr_ctrl   = reg_wr_i && (reg_addr_i == OFS_CTRL);
  wire logic wr_wake   = reg_wr_i && (reg_addr_i == OFS_WAKE_LEVEL);
  wire logic wr_sleep  = reg_wr_i && (reg_addr_i == OFS_SLEEP_LEVEL);
  wire logic wr_wtime  = reg_wr_i && (reg_addr_i == OFS_WAKE_TIME);
  wire logic wr_stime  = reg_wr_i && (reg_addr_i == OFS_SLEEP_TIME);

  // Levels and times accepted without limits, also while running
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_reg        <= CTRL_RST;
      wake_level_reg  <= LEVEL_RST;
      sleep_level_reg <= LEVEL_RST;
      wake_time_reg   <= TIME_RST;
      sleep_time_reg  <= TIME_RST;
    end else begin
      if (wr_ctrl)  ctrl_reg        <= reg_wdata_i;
      if (wr_wake)  wake_level_reg  <= reg_wdata_i[AIN_W-1:0]; // RL14 RL15
      if (wr_sleep) sleep_level_reg <= reg_wdata_i[AIN_W-1:0]; // RL14 RL15
      if (wr_wtime) wake_time_reg   <= reg_wdata_i[TMR_W-1:0];
      if (wr_stime) sleep_time_reg  <= reg_wdata_i[TMR_W-1:0];
    end
  end

  wire logic [CTRL_MODE_W-1:0] mode = ctrl_reg[CTRL_MODE_LSB +: CTRL_MODE_W];
  wire logic [SEL_W-1:0]       src  = ctrl_reg[CTRL_SRC_LSB +: SEL_W];
  wire logic direct = (mode == MODE_DIRECT); // RL3

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  localparam int TDIV_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TDIV_W-1:0] TDIV_LAST = TDIV_W'(TICK_CYCLES - 1);
  logic [TDIV_W-1:0] tdiv_reg;
  logic              tick_reg;
  wire logic tdiv_wrap = (tdiv_reg == TDIV_LAST);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tdiv_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tdiv_reg <= tdiv_wrap ? '0 : tdiv_reg + 1'b1;
      tick_reg <= tdiv_wrap;
    end
  end

  // ----------------------------------------------------------------
  // Source selection and comparison
  // ----------------------------------------------------------------
  wire logic [AIN_W-1:0] ain_sel =
    (src == 2'h0) ? ain0_i :
    (src == 2'h1) ? ain1_i :
    (src == 2'h2) ? ain2_i : ain3_i; // RL17
  wire logic [AIN_W-1:0] ain_abs   = abs_val(ain_sel); // RL18
  wire logic             wake_met  = direct && (ain_abs >= wake_level_reg); // RL1
  wire logic             sleep_met = direct && (ain_abs <= sleep_level_reg); // RL2
  wire logic             crossed   = sleep_level_reg > wake_level_reg; // RL14

  // ----------------------------------------------------------------
  // Qualification timers
  // ----------------------------------------------------------------
  logic [TMR_W-1:0] wake_cnt;
  logic [TMR_W-1:0] sleep_cnt;
  logic             wake_sat;
  logic             sleep_sat;
  logic             wake_edge;
  logic             sleep_edge;

  swk_qual_timer u_wake_tmr (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .tick_i    (tick_reg),
    .cond_i    (wake_met),
    .limit_i   (wake_time_reg),
    .cnt_o     (wake_cnt),
    .sat_o     (wake_sat),
    .edge_o    (wake_edge)
  );

  swk_qual_timer u_sleep_tmr (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .tick_i    (tick_reg),
    .cond_i    (sleep_met),
    .limit_i   (sleep_time_reg),
    .cnt_o     (sleep_cnt),
    .sat_o     (sleep_sat),
    .edge_o    (sleep_edge)
  );

  // ----------------------------------------------------------------
  // Sleep/wake state
  // ----------------------------------------------------------------
  swk_state_type state_reg;
  swk_state_type state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SWK_ASLEEP: if (wake_edge && !crossed) state_next = SWK_AWAKE; // RL8 RL16
      SWK_AWAKE:  if (sleep_edge) state_next = SWK_ASLEEP; // RL8 RL15
      default:    state_next = SWK_ASLEEP;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= SWK_ASLEEP; // RL9
    end else begin
      state_reg <= state_next;
    end
  end

  wire logic wake_go = (state_reg == SWK_ASLEEP) && (state_next == SWK_AWAKE);

  // ----------------------------------------------------------------
  // Start and stop decisions
  // ----------------------------------------------------------------
  wire logic bypass     = !direct || jog_i || local_ctrl_i; // RL3 RL11 RL12
  wire logic base_ok    = permissives_ok_i && run_input_closed_i; // RL4
  wire logic sleep_stop = !bypass && sleep_sat; // RL10
  wire logic cross_lock = !bypass && crossed && !running_i; // RL14 RL16
  wire logic term_start = local_ctrl_i && (local_port_i == TERMINAL_PORT) && din_start_i; // RL13
  wire logic other_start = local_ctrl_i ? (local_start_i || term_start) : start_cmd_i; // RL11
  wire logic permit     = base_ok && !sleep_stop && !cross_lock;
  wire logic wake_start = direct && !bypass && wake_go && base_ok; // RL1 RL5
  wire logic start_next = (other_start && permit) || wake_start; // RL5 RL6 RL10
  wire logic stop_next  = sleep_stop && !(other_start && bypass); // RL2

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      drive_start_o <= 1'b0;
      drive_stop_o  <= 1'b0;
      run_permit_o  <= 1'b0; // RL9
      fault_reset_o <= 1'b0;
      awake_o       <= 1'b0;
      crossed_o     <= 1'b0;
      ain_loss_o    <= '0;
    end else begin
      drive_start_o <= start_next;
      drive_stop_o  <= stop_next;
      run_permit_o  <= permit;
      fault_reset_o <= fault_reset_i; // RL6
      awake_o       <= (state_next == SWK_AWAKE);
      crossed_o     <= crossed;
      ain_loss_o    <= ain_loss_i; // RL19
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  wire logic [DATA_W-1:0] status_word;
  wire logic [DATA_W-1:0] timers_word;

  assign status_word[ST_AWAKE]            = awake_o;
  assign status_word[ST_WSAT]             = wake_sat;
  assign status_word[ST_SSAT]             = sleep_sat;
  assign status_word[ST_CROSSED]          = crossed_o;
  assign status_word[ST_PERMIT]           = run_permit_o;
  assign status_word[ST_STOP]             = drive_stop_o;
  assign status_word[DATA_W-1:ST_STOP+1]  = '0;
  assign timers_word[TMR_HI_LSB +: TMR_W] = sleep_cnt;
  assign timers_word[TMR_W-1:0]           = wake_cnt;
  wire logic [DATA_W-1:0] rd_mux =
    (reg_addr_i == OFS_CTRL)        ? ctrl_reg :
    (reg_addr_i == OFS_WAKE_LEVEL)  ? zext16(wake_level_reg) :
    (reg_addr_i == OFS_SLEEP_LEVEL) ? zext16(sleep_level_reg) :
    (reg_addr_i == OFS_WAKE_TIME)   ? zext16(wake_time_reg) :
    (reg_addr_i == OFS_SLEEP_TIME)  ? zext16(sleep_time_reg) :
    (reg_addr_i == OFS_STATUS)      ? status_word :
    (reg_addr_i == OFS_TIMERS)      ? timers_word : '0;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_wake_needs_level: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL1
    wake_edge |-> $past(ain_abs >= wake_level_reg) || wake_time_reg == '0)
    else $error("wake edge without wake level");
  a_sleep_stops_drive: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL10
    sleep_sat && direct && !jog_i && !local_ctrl_i |=> drive_stop_o && !run_permit_o)
    else $error("sleep satisfied but drive not stopped");
  a_mode_off_inert: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL3
    !direct |=> !drive_stop_o) else $error("stop asserted outside direct mode");
  a_permit_needs_input: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL4
    !run_input_closed_i || !permissives_ok_i |=> !run_permit_o)
    else $error("permit without closed run input");
  a_jog_bypasses: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL12
    jog_i && base_ok |=> run_permit_o) else $error("jog blocked by sleep");
  a_terminal_start: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL13
    term_start && base_ok |=> drive_start_o) else $error("terminal start blocked");
  a_crossed_no_wake: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL16
    state_reg == SWK_ASLEEP && crossed |=> state_reg == SWK_ASLEEP)
    else $error("woke while thresholds crossed");
  a_fault_reset_pass: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL6
    fault_reset_i |=> fault_reset_o) else $error("fault reset blocked");
  a_loss_independent: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL19
    ##1 ain_loss_o == $past(ain_loss_i)) else $error("loss flags altered");
  a_wake_starts: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL5
    wake_go && direct && !bypass && base_ok |=> drive_start_o ##1 !drive_start_o || start_next)
    else $error("wake edge did not start drive");

  // ----------------------------------------------------------------
  // Timer, state and magnitude checks
  // ----------------------------------------------------------------
  a_wake_sat_level: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL1
    wake_sat |-> $past(wake_met)) else $error("wake timer met without level");

  a_sleep_sat_level: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL2
    sleep_sat |-> $past(sleep_met)) else $error("sleep timer met without level");

  a_wake_cnt_down: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL7
    tick_reg && !wake_met && wake_cnt != '0 |=> wake_cnt == $past(wake_cnt) - 1'b1)
    else $error("wake timer failed to count down");

  a_sleep_cnt_down: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL7
    tick_reg && !sleep_met && sleep_cnt != '0 |=> sleep_cnt == $past(sleep_cnt) - 1'b1)
    else $error("sleep timer failed to count down");

  a_wake_edge_awake: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL8
    wake_edge && !crossed && state_reg == SWK_ASLEEP |=> state_reg == SWK_AWAKE)
    else $error("wake edge ignored");

  a_sleep_edge_asleep: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL8
    sleep_edge && state_reg == SWK_AWAKE |=> state_reg == SWK_ASLEEP)
    else $error("sleep edge ignored");

  a_mode_off_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL3
    !direct |=> !wake_sat && !sleep_sat) else $error("timer met outside direct mode");

  a_abs_no_sign: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL18
    ain_sel != {1'b1, {(AIN_W-1){1'b0}}} |-> !ain_abs[AIN_W-1])
    else $error("magnitude still negative");

  // ----------------------------------------------------------------
  // Start and stop checks
  // ----------------------------------------------------------------
  a_stop_needs_sat: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL2
    drive_stop_o |-> $past(sleep_sat)) else $error("stop without sleep");

  a_start_needs_base: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL4
    drive_start_o |-> $past(base_ok)) else $error("start without permissives");

  a_wake_no_block: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL6
    start_cmd_i && !local_ctrl_i && permit |=> drive_start_o)
    else $error("start command blocked");

  a_sleep_blocks_start: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL10
    sleep_sat && direct && !jog_i && !local_ctrl_i && !wake_go |=> !drive_start_o)
    else $error("start while asleep");

  a_local_overrides: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL11
    local_ctrl_i && base_ok |=> run_permit_o) else $error("local control blocked");

  a_local_start: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL11
    local_ctrl_i && local_start_i && base_ok |=> drive_start_o)
    else $error("local start blocked");

  a_jog_no_stop: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL12
    jog_i |=> !drive_stop_o) else $error("stop during jog");

  a_term_port_only: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL13
    local_ctrl_i && local_port_i != TERMINAL_PORT && !local_start_i |=> !drive_start_o)
    else $error("digital start from other port");

  a_cross_locks_start: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL14
    crossed && !running_i && direct && !jog_i && !local_ctrl_i |=> !run_permit_o)
    else $error("permit with crossed levels");

  a_cross_run_keeps: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL15
    crossed && running_i && base_ok && !sleep_sat |=> run_permit_o)
    else $error("crossed levels stopped run");

  a_rdata_one_cycle: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !reg_rd_i |=> reg_rdata_o == '0) else $error("read data held too long");
endmodule : swk_top
`default_nettype wire

/* swk_pkg.sv */
// What this block does
// RL1 - Wake level met, timed, starts drive
// RL2 - Sleep level met, timed, stops drive
// RL3 - Active only in direct mode
// RL4 - Permissives and closed run input still required
// RL5 - Fault restart by wake edge or start
// RL6 - Wake never blocks fault reset or starts
// RL7 - Timers count up when met, down otherwise
// RL8 - Timer at target toggles sleep or wake
// RL9 - Power-up timers cleared, no start permitted
// RL10 - Sleep satisfied acts as continuous stop
// RL11 - Local control overrides sleep and wake
// RL12 - Jog overrides sleep and wake
// RL13 - Terminal port local start overrides sleep
// RL14 - Crossed thresholds accepted but start refused
// RL15 - Levels writable; crossed run continues until sleep
// RL16 - Crossed sleep locks until levels corrected
// RL17 - Any analog input selectable as source
// RL18 - Absolute calibrated value, scaling ignored
// RL19 - Input loss detection stays independent
// RL20 - Timers saturate, never wrap
package swk_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int AIN_W  = 16;
  localparam int TMR_W  = 16;
  localparam int NUM_AIN = 4;
  localparam int SEL_W  = 2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_WAKE_LEVEL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SLEEP_LEVEL= 8'h08;
  localparam logic [ADDR_W-1:0] OFS_WAKE_TIME  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_SLEEP_TIME = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_TIMERS     = 8'h18;

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W   = 2;
  localparam int CTRL_SRC_LSB  = 4;
  localparam logic [CTRL_MODE_W-1:0] MODE_DISABLED = 2'h0;
  localparam logic [CTRL_MODE_W-1:0] MODE_DIRECT   = 2'h1;
  localparam int ST_AWAKE   = 0;
  localparam int ST_WSAT    = 1;
  localparam int ST_SSAT    = 2;
  localparam int ST_CROSSED = 3;
  localparam int ST_PERMIT  = 4;
  localparam int ST_STOP    = 5;
  localparam int TMR_HI_LSB = 16;
  localparam logic [SEL_W-1:0] TERMINAL_PORT = 2'h0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [AIN_W-1:0]  LEVEL_RST = 16'h0000;
  localparam logic [TMR_W-1:0]  TIME_RST  = 16'h0000;

  // ----------------------------------------------------------------
  // Timing: timers count in milliseconds
  // ----------------------------------------------------------------
  localparam int REF_CLK_KHZ   = 25000;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES   = REF_CLK_KHZ * TICK_PERIOD_US / 1000;

  typedef enum logic [1:0] {
    SWK_ASLEEP = 2'b01,
    SWK_AWAKE  = 2'b10
  } swk_state_type;
endpackage : swk_pkg

/* swk_qual_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module swk_qual_timer (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_b_i,
  input  wire logic                     tick_i,
  input  wire logic                     cond_i,
  input  wire logic [swk_pkg::TMR_W-1:0] limit_i,
  output logic      [swk_pkg::TMR_W-1:0] cnt_o,
  output logic                          sat_o,
  output logic                          edge_o
);
  import swk_pkg::*;

  // ----------------------------------------------------------------
  // Up/down count with saturation
  // ----------------------------------------------------------------
  wire logic             at_top = (cnt_o >= limit_i);
  wire logic [TMR_W-1:0] up_val = at_top ? limit_i : cnt_o + 1'b1;
  wire logic [TMR_W-1:0] dn_val = (cnt_o == '0) ? cnt_o : cnt_o - 1'b1;
  wire logic [TMR_W-1:0] cnt_next = !tick_i ? cnt_o : (cond_i ? up_val : dn_val); // RL7 RL20
  wire logic             sat_next = cond_i && (cnt_next >= limit_i);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_o  <= '0; // RL9
      sat_o  <= 1'b0;
      edge_o <= 1'b0;
    end else begin
      cnt_o  <= cnt_next;
      sat_o  <= sat_next;
      edge_o <= sat_next && !sat_o; // RL8
    end
  end

  a_timer_no_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL20
    $past(cnt_o) == '0 && !$past(cond_i) |-> cnt_o == '0) else $error("timer wrapped below zero");
  a_timer_up_step: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL7
    tick_i && cond_i && cnt_o < limit_i |=> cnt_o == $past(cnt_o) + 1'b1) else $error("timer failed to count up");
  a_timer_edge_once: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // RL8
    edge_o |=> !edge_o) else $error("edge longer than one cycle");
endmodule : swk_qual_timer
`default_nettype wire

/* swk_drive_model.sv */
`timescale 1ns/1ns
`default_nettype none
module swk_drive_model (
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_b_i,
  input  wire logic [swk_pkg::SEL_W-1:0] src_i,
  input  wire logic [swk_pkg::AIN_W-1:0] level_i,
  input  wire logic                      drive_start_i,
  input  wire logic                      drive_stop_i,
  output logic      [swk_pkg::AIN_W-1:0] ain0_o,
  output logic      [swk_pkg::AIN_W-1:0] ain1_o,
  output logic      [swk_pkg::AIN_W-1:0] ain2_o,
  output logic      [swk_pkg::AIN_W-1:0] ain3_o,
  output logic                           running_o
);
  import swk_pkg::*;
  logic [AIN_W-1:0] noise_reg;
  // Channels not selected carry a moving pattern
  assign ain0_o = (src_i == 2'h0) ? level_i : noise_reg;
  assign ain1_o = (src_i == 2'h1) ? level_i : ~noise_reg;
  assign ain2_o = (src_i == 2'h2) ? level_i : noise_reg;
  assign ain3_o = (src_i == 2'h3) ? level_i : ~noise_reg;
  // Drive runs after a start and halts on a stop
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      noise_reg <= 16'h0000;
      running_o <= 1'b0;
    end else begin
      noise_reg <= noise_reg + 16'h1357;
      if (drive_stop_i) begin
        running_o <= 1'b0;
      end else if (drive_start_i) begin
        running_o <= 1'b1;
      end
    end
  end
endmodule : swk_drive_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import swk_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [15:0] a0, a1, a2, a3, level = 16'h0000;
  logic [3:0]  loss = 4'h0, loss_o;
  logic        perm = 1'b1, runin = 1'b1, running, frst = 1'b0, start = 1'b0;
  logic        lctl = 1'b0, lstart = 1'b0, din = 1'b0, jog = 1'b0;
  logic [1:0]  lport = 2'h0;
  logic        dstart, dstop, permit, frst_o, awake, crossed;
  int          n_errors = 0;
  int          checks_done = 0;
  always #20 clk = ~clk;
  swk_top #(.TICK_CYCLES(4)) dut_u (.ref_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .ain0_i(a0), .ain1_i(a1), .ain2_i(a2), .ain3_i(a3),
    .ain_loss_i(loss), .permissives_ok_i(perm), .run_input_closed_i(runin), .running_i(running),
    .fault_reset_i(frst), .start_cmd_i(start), .local_ctrl_i(lctl), .local_port_i(lport),
    .local_start_i(lstart), .din_start_i(din), .jog_i(jog), .drive_start_o(dstart), .drive_stop_o(dstop),
    .run_permit_o(permit), .fault_reset_o(frst_o), .awake_o(awake), .crossed_o(crossed), .ain_loss_o(loss_o));
  swk_drive_model model_u (.ref_clk_i(clk), .rst_b_i(rst_b), .src_i(2'h2), .level_i(level),
    .drive_start_i(dstart), .drive_stop_i(dstop), .ain0_o(a0), .ain1_o(a1), .ain2_o(a2), .ain3_o(a3),
    .running_o(running));
  task print_verdict;
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  function automatic logic pick(input int k);
    case (k)
      0: pick = dstart;
      1: pick = dstop;
      2: pick = awake;
      3: pick = crossed;
      default: pick = permit;
    endcase
  endfunction : pick
  task wait_sig(input int k, input logic v, input string nm);
    for (int i = 0; i < 300 && pick(k) !== v; i++) @(negedge clk);
    chk(nm, {31'h0, v}, {31'h0, pick(k)});
    if (pick(k) !== v) print_verdict();
  endtask : wait_sig
  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
    @(posedge clk) wr <= 1'b0;
  endtask : reg_wr
  task reg_rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) chk(nm, exp, rdata);
  endtask : reg_rd
  task set_level(input logic [15:0] v);
    @(posedge clk) level <= v;
  endtask : set_level
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    reg_rd(OFS_STATUS, 32'h1 << ST_PERMIT, "status");
    reg_rd(OFS_TIMERS, 32'h0, "timers");
    reg_rd(8'h40, 32'h0, "unmapped");
    chk("start", 32'h0, {31'h0, dstart});
  endtask : t_reset
  task t_mode_off;
    reg_wr(OFS_WAKE_LEVEL, 32'h64);
    reg_wr(OFS_SLEEP_LEVEL, 32'h32);
    reg_wr(OFS_WAKE_TIME, 32'h2);
    reg_wr(OFS_SLEEP_TIME, 32'h2);
    reg_rd(OFS_WAKE_LEVEL, 32'h64, "wake level");
    set_level(16'hff38);
    repeat (40) @(negedge clk);
    chk("awake off", 32'h0, {31'h0, awake});
  endtask : t_mode_off
  task t_wake;
    reg_wr(OFS_CTRL, 32'h21);
    wait_sig(0, 1'b1, "wake start");
    chk("awake", 32'h1, {31'h0, awake});
    @(negedge clk) chk("start pulse", 32'h0, {31'h0, dstart});
    repeat (30) @(negedge clk);
    reg_rd(OFS_TIMERS, 32'h0000_0002, "timers up");
  endtask : t_wake
  task t_crossed;
    set_level(16'h01f4);
    reg_wr(OFS_SLEEP_LEVEL, 32'h12c);
    wait_sig(3, 1'b1, "crossed");
    repeat (30) @(negedge clk);
    chk("run on", 32'h1, {31'h0, permit});
    set_level(16'h00c8);
    wait_sig(1, 1'b1, "crossed sleep");
    wait_sig(4, 1'b0, "permit off");
    set_level(16'h01f4);
    repeat (40) @(negedge clk);
    chk("locked", 32'h0, {31'h0, awake});
    reg_wr(OFS_SLEEP_LEVEL, 32'h32);
    set_level(16'h000a);
    repeat (30) @(negedge clk);
    reg_rd(OFS_TIMERS, 32'h0002_0000, "timers down");
    set_level(16'h01f4);
    wait_sig(0, 1'b1, "rewake");
  endtask : t_crossed
  task t_bypass;
    logic seen;
    seen = 1'b0;
    set_level(16'h000a);
    wait_sig(1, 1'b1, "sleep stop");
    wait_sig(4, 1'b0, "sleep permit");
    @(posedge clk) start <= 1'b1;
    repeat (20) @(negedge clk) seen |= dstart;
    chk("start held", 32'h0, {31'h0, seen});
    @(posedge clk) begin start <= 1'b0; jog <= 1'b1; end
    wait_sig(4, 1'b1, "jog permit");
    @(posedge clk) jog <= 1'b0;
    wait_sig(4, 1'b0, "jog off");
    @(posedge clk) begin lctl <= 1'b1; din <= 1'b1; end
    wait_sig(4, 1'b1, "local permit");
    @(posedge clk) begin lctl <= 1'b0; din <= 1'b0; end
    wait_sig(4, 1'b0, "local off");
  endtask : t_bypass
  task t_sides;
    @(posedge clk) begin frst <= 1'b1; loss <= 4'ha; jog <= 1'b1; end
    @(posedge clk) frst <= 1'b0;
    @(negedge clk) chk("fault reset", 32'h1, {31'h0, frst_o});
    chk("loss", 32'ha, {28'h0, loss_o});
    wait_sig(4, 1'b1, "jog permit");
    @(posedge clk) perm <= 1'b0;
    wait_sig(4, 1'b0, "no permissive");
    @(posedge clk) begin perm <= 1'b1; runin <= 1'b0; end
    repeat (3) @(negedge clk);
    chk("no run input", 32'h0, {31'h0, permit});
  endtask : t_sides
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_mode_off();
    t_wake();
    t_crossed();
    t_bypass();
    t_sides();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
